// ==== design/eefm_pkg.sv ====
// package: register map, field positions and reset values of the extended event flag and mask block
package eefm_pkg;
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned NUM_BYTES    = 3;
  // volatile register addresses
  localparam logic [7:0] ADDR_FLAGS2   = 8'hCD;
  localparam logic [7:0] ADDR_FLAGS1   = 8'hCE;
  localparam logic [7:0] ADDR_FLAGS0   = 8'hCF;
  localparam logic [7:0] ADDR_MASK2    = 8'hD0;
  localparam logic [7:0] ADDR_MASK1    = 8'hD1;
  localparam logic [7:0] ADDR_MASK0    = 8'hD2;
  // non-volatile mask copies
  localparam logic [7:0] ADDR_NVMASK2  = 8'h80;
  localparam logic [7:0] ADDR_NVMASK1  = 8'h81;
  localparam logic [7:0] ADDR_NVMASK0  = 8'h82;
  // byte 0 field positions
  localparam int unsigned B0_SER_OVF   = 0;
  localparam int unsigned B0_RF_OVF    = 1;
  localparam int unsigned B0_WR_FAIL   = 2;
  localparam int unsigned B0_ACK_MISS  = 3;
  localparam int unsigned B0_PAY_CRC   = 4;
  localparam int unsigned B0_HDR_CRC   = 5;
  localparam int unsigned B0_ACK_SEQ   = 6;
  localparam int unsigned B0_FRAME     = 7;
  // byte 1 field positions
  localparam int unsigned B1_TX_DONE   = 0;
  localparam int unsigned B1_RX_PEND   = 1;
  localparam int unsigned B1_PLAIN     = 2;
  localparam int unsigned B1_SEQ_DEC   = 3;
  localparam int unsigned B1_SEQ_SKIP  = 4;
  localparam int unsigned B1_PAIRING   = 5;
  // implemented bits per flag byte; reserved bits read zero
  localparam logic [7:0] IMPL_MASK0    = 8'hFF;
  localparam logic [7:0] IMPL_MASK1    = 8'h3F;
  localparam logic [7:0] IMPL_MASK2    = 8'h00;
  // reset values
  localparam logic [7:0] FLAGS_RESET   = 8'h00;
  localparam logic [7:0] MASK_RESET    = 8'h00;
  localparam logic [7:0] READ_DEFAULT  = 8'h00;
endpackage : eefm_pkg

// ==== design/eefm_nv_mask.sv ====
// non-volatile copy of the three mask bytes, stands in for persistent storage
`timescale 1ns/1ps
module eefm_nv_mask
  import eefm_pkg::*;
#(
  parameter logic [7:0] NV_DEFAULT2 = 8'h00,
  parameter logic [7:0] NV_DEFAULT1 = 8'h00,
  parameter logic [7:0] NV_DEFAULT0 = 8'h00
) (
  input  wire logic                      clock,
  input  wire logic                      nrst,
  input  wire logic                      wr_en,
  input  wire logic [eefm_pkg::ADDR_W-1:0] wr_addr,
  input  wire logic [eefm_pkg::DATA_W-1:0] wr_data,
  output logic      [eefm_pkg::DATA_W-1:0] nv_byte2,
  output logic      [eefm_pkg::DATA_W-1:0] nv_byte1,
  output logic      [eefm_pkg::DATA_W-1:0] nv_byte0
);
  logic [7:0] next_nv2, next_nv1, next_nv0;

  ////////////////////////////////////////////////////////////////////////////////
  // a real part keeps these across power loss; here reset loads fixed defaults
  always_comb begin
    next_nv2 = nv_byte2;
    next_nv1 = nv_byte1;
    next_nv0 = nv_byte0;
    if (wr_en) begin
      if (wr_addr == ADDR_NVMASK2) begin
        next_nv2 = wr_data;
      end else if (wr_addr == ADDR_NVMASK1) begin
        next_nv1 = wr_data;
      end else if (wr_addr == ADDR_NVMASK0) begin
        next_nv0 = wr_data;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      nv_byte2 <= NV_DEFAULT2;
      nv_byte1 <= NV_DEFAULT1;
      nv_byte0 <= NV_DEFAULT0;
    end else begin
      nv_byte2 <= next_nv2;
      nv_byte1 <= next_nv1;
      nv_byte0 <= next_nv0;
    end
  end
endmodule // eefm_nv_mask

// ==== design/eefm_core.sv ====
// extended event flags, masks and event output line
`timescale 1ns/1ps

module eefm_core
  import eefm_pkg::*;
#(
  parameter int unsigned SEQ_W = 8
) (
  input  wire logic                        clock,
  input  wire logic                        nrst,
  // host register port
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [eefm_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [eefm_pkg::DATA_W-1:0] reg_wdata,
  output logic      [eefm_pkg::DATA_W-1:0] reg_rdata,
  output logic                             reg_hit,
  // legacy mask from the surrounding exception logic
  input  wire logic [7:0]                  legacy_event_mask,
  // internal event pulses
  input  wire logic                        serial_buffer_overflow,
  input  wire logic                        radio_buffer_overflow,
  input  wire logic                        reg_write_failed,
  input  wire logic                        ack_missing,
  input  wire logic                        payload_crc_error,
  input  wire logic                        header_crc_error,
  input  wire logic                        ack_seq_mismatch,
  input  wire logic                        frame_type_unsupported,
  input  wire logic                        packet_sent,
  input  wire logic                        packet_ack_requested,
  input  wire logic                        ack_received,
  input  wire logic                        rx_bytes_waiting,
  input  wire logic                        rx_packet_valid,
  input  wire logic                        rx_packet_encrypted,
  input  wire logic [SEQ_W-1:0]            rx_seq_num,
  input  wire logic                        accept_plaintext,
  input  wire logic                        pairing_start,
  // status line
  output logic                             event_out_line
);
  logic [7:0] ext_event_flags [NUM_BYTES];
  logic [7:0] next_flags      [NUM_BYTES];
  logic [7:0] ext_event_mask  [NUM_BYTES];
  logic [7:0] next_mask       [NUM_BYTES];
  logic [7:0] set_vec         [NUM_BYTES];
  logic [7:0] impl_vec        [NUM_BYTES];
  logic [7:0] nv_mask         [NUM_BYTES];
  logic [NUM_BYTES-1:0] flag_wr_sel;
  logic [NUM_BYTES-1:0] mask_wr_sel;
  logic [NUM_BYTES-1:0] byte_hit;
  logic                 mask_loaded;
  logic                 next_mask_loaded;
  logic                 tx_wait_ack;
  logic                 next_tx_wait_ack;
  logic                 tx_complete_flag;
  logic                 seq_valid;
  logic                 next_seq_valid;
  logic [SEQ_W-1:0]     last_seq;
  logic [SEQ_W-1:0]     next_last_seq;
  logic [SEQ_W-1:0]     seq_plus_one;
  logic                 sequence_decreased;
  logic                 sequence_skipped;
  logic                 plaintext_received;
  logic                 enc_rx;
  logic [7:0]           next_rdata;
  logic                 next_hit;
  logic                 nv_wr;

  ////////////////////////////////////////////////////////////////////////////////
  // saved mask copies; their write strobe comes from the address decode below

  eefm_nv_mask u_nv (
    .clock    (clock),
    .nrst     (nrst),
    .wr_en    (nv_wr),
    .wr_addr  (reg_addr),
    .wr_data  (reg_wdata),
    .nv_byte2 (nv_mask[2]),
    .nv_byte1 (nv_mask[1]),
    .nv_byte0 (nv_mask[0])
  );

  ////////////////////////////////////////////////////////////////////////////////
  // transmit completion and sequence tracking
  always_comb begin
    next_tx_wait_ack = tx_wait_ack;
    tx_complete_flag = 1'b0;
    if (packet_sent && !packet_ack_requested) begin
      tx_complete_flag = 1'b1;
    end else if (packet_sent) begin
      next_tx_wait_ack = 1'b1;
    end
    if (tx_wait_ack && ack_received) begin
      tx_complete_flag = 1'b1;
      next_tx_wait_ack = 1'b0;
    end
    // giving up on the ack ends the wait, so a late ack cannot complete the send
    if (ack_missing) begin
      next_tx_wait_ack = 1'b0;
    end
    next_seq_valid = seq_valid;
    next_last_seq  = last_seq;
    if (enc_rx) begin
      next_seq_valid = 1'b1;
      next_last_seq  = rx_seq_num;
    end
  end

  assign enc_rx             = rx_packet_valid && rx_packet_encrypted;
  assign seq_plus_one       = rx_seq_num - SEQ_W'(1);
  // first encrypted packet after reset has no predecessor to compare with
  // no wraparound handling: a counter rolling over reads as a decrease
  assign sequence_decreased = enc_rx && seq_valid && (rx_seq_num < last_seq);
  assign sequence_skipped   = enc_rx && seq_valid && (rx_seq_num > last_seq)
                              && (seq_plus_one > last_seq);
  assign plaintext_received = rx_packet_valid && !rx_packet_encrypted && accept_plaintext;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_wait_ack <= 1'b0;
      seq_valid   <= 1'b0;
      last_seq    <= '0;
    end else begin
      tx_wait_ack <= next_tx_wait_ack;
      seq_valid   <= next_seq_valid;
      last_seq    <= next_last_seq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // event set vectors
  always_comb begin
    set_vec[0] = '0;
    set_vec[1] = '0;
    set_vec[2] = '0;
    set_vec[0][B0_SER_OVF]  = serial_buffer_overflow;
    set_vec[0][B0_RF_OVF]   = radio_buffer_overflow;
    set_vec[0][B0_WR_FAIL]  = reg_write_failed;
    set_vec[0][B0_FRAME]    = frame_type_unsupported;
    set_vec[0][B0_ACK_MISS] = ack_missing;
    set_vec[0][B0_PAY_CRC]  = payload_crc_error;
    set_vec[0][B0_HDR_CRC]  = header_crc_error;
    set_vec[0][B0_ACK_SEQ]  = ack_seq_mismatch;
    set_vec[1][B1_TX_DONE]  = tx_complete_flag;
    set_vec[1][B1_PLAIN]    = plaintext_received;
    set_vec[1][B1_SEQ_DEC]  = sequence_decreased;
    set_vec[1][B1_SEQ_SKIP] = sequence_skipped;
    set_vec[1][B1_PAIRING]  = pairing_start;
  end

  assign impl_vec[0] = IMPL_MASK0;
  assign impl_vec[1] = IMPL_MASK1;
  assign impl_vec[2] = IMPL_MASK2;

  ////////////////////////////////////////////////////////////////////////////////
  // address decode, byte 2 at the low address
  always_comb begin
    flag_wr_sel = '0;
    mask_wr_sel = '0;
    nv_wr       = 1'b0;
    if (reg_wr && reg_addr == ADDR_FLAGS2) begin
      flag_wr_sel[2] = 1'b1;
    end else if (reg_wr && reg_addr == ADDR_FLAGS1) begin
      flag_wr_sel[1] = 1'b1;
    end else if (reg_wr && reg_addr == ADDR_FLAGS0) begin
      flag_wr_sel[0] = 1'b1;
    end else if (reg_wr && reg_addr == ADDR_MASK2) begin
      mask_wr_sel[2] = 1'b1;
    end else if (reg_wr && reg_addr == ADDR_MASK1) begin
      mask_wr_sel[1] = 1'b1;
    end else if (reg_wr && reg_addr == ADDR_MASK0) begin
      mask_wr_sel[0] = 1'b1;
    end else if (reg_wr && reg_addr == ADDR_NVMASK2) begin
      nv_wr = 1'b1;
    end else if (reg_wr && reg_addr == ADDR_NVMASK1) begin
      nv_wr = 1'b1;
    end else if (reg_wr && reg_addr == ADDR_NVMASK0) begin
      nv_wr = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // flag and mask bytes
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BYTES; gi++) begin : g_byte
      always_comb begin
        next_flags[gi] = ext_event_flags[gi];
        if (flag_wr_sel[gi]) begin
          next_flags[gi] = ext_event_flags[gi] & reg_wdata;
        end
        // a same-cycle event wins over the clearing write
        next_flags[gi] = (next_flags[gi] | set_vec[gi]) & impl_vec[gi];
        if (gi == 1) begin
          next_flags[gi][B1_RX_PEND] = rx_bytes_waiting;
        end
        next_mask[gi] = ext_event_mask[gi];
        if (!mask_loaded) begin
          next_mask[gi] = nv_mask[gi];
        end else if (mask_wr_sel[gi]) begin
          next_mask[gi] = reg_wdata;
        end
      end

      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          ext_event_flags[gi] <= FLAGS_RESET;
          ext_event_mask[gi]  <= MASK_RESET;
        end else begin
          ext_event_flags[gi] <= next_flags[gi];
          ext_event_mask[gi]  <= next_mask[gi];
        end
      end

      assign byte_hit[gi] = |(ext_event_flags[gi] & ext_event_mask[gi]);
    end
  endgenerate

  // the saved-copy load takes the first edge after reset; a mask write there is lost
  always_comb begin
    next_mask_loaded = 1'b1;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mask_loaded <= 1'b0;
    end else begin
      mask_loaded <= next_mask_loaded;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // event output line, combinational so a clear shows the next cycle
  // legacy mask comes from logic on this clock, so no synchroniser sits on it
  assign event_out_line = (legacy_event_mask == 8'h00) && (|byte_hit);

  ////////////////////////////////////////////////////////////////////////////////
  // read port; reads have no side effect
  // a read in the same cycle as a write returns the old value
  always_comb begin
    next_rdata = READ_DEFAULT;
    next_hit   = 1'b1;
    if (reg_addr == ADDR_FLAGS2) begin
      next_rdata = ext_event_flags[2];
    end else if (reg_addr == ADDR_FLAGS1) begin
      next_rdata = ext_event_flags[1];
    end else if (reg_addr == ADDR_FLAGS0) begin
      next_rdata = ext_event_flags[0];
    end else if (reg_addr == ADDR_MASK2) begin
      next_rdata = ext_event_mask[2];
    end else if (reg_addr == ADDR_MASK1) begin
      next_rdata = ext_event_mask[1];
    end else if (reg_addr == ADDR_MASK0) begin
      next_rdata = ext_event_mask[0];
    end else if (reg_addr == ADDR_NVMASK2) begin
      next_rdata = nv_mask[2];
    end else if (reg_addr == ADDR_NVMASK1) begin
      next_rdata = nv_mask[1];
    end else if (reg_addr == ADDR_NVMASK0) begin
      next_rdata = nv_mask[0];
    end else begin
      next_hit = 1'b0;
    end
    // outside a read the last answer stands until the next one
    if (!reg_rd) begin
      next_rdata = reg_rdata;
      next_hit   = reg_hit;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= READ_DEFAULT;
      reg_hit   <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      reg_hit   <= next_hit;
    end
  end
endmodule // eefm_core

// ==== tb/eefm_sva.sv ====
// port checker for the extended event flag and mask block
`timescale 1ns/1ps
module eefm_sva
  import eefm_pkg::*;
(
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_hit,
  input wire logic [7:0] legacy_event_mask,
  input wire logic       rx_bytes_waiting,
  input wire logic       event_out_line
);
  logic mapped;
  assign mapped = reg_addr inside {[ADDR_NVMASK2:ADDR_NVMASK0], [ADDR_FLAGS2:ADDR_MASK0]};
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  chk_legacy_quiet:
    assert property (legacy_event_mask != 8'h00 |-> !event_out_line) else $error("line high under legacy mask");
  // rx pending may drop on its own, so only other flags count here
  chk_flag_sticky:
    assert property (event_out_line && !reg_wr && legacy_event_mask == 8'h00 && !rx_bytes_waiting &&
      !$past(rx_bytes_waiting) |=> event_out_line || legacy_event_mask != 8'h00) else $error("line fell without write");
  chk_rx_follow:
    assert property (reg_rd && reg_addr == ADDR_FLAGS1 |=> reg_rdata[B1_RX_PEND] == $past(rx_bytes_waiting, 2))
      else $error("rx pending bit wrong");
  chk_byte2_zero:
    assert property (reg_rd && reg_addr == ADDR_FLAGS2 |=> reg_rdata == 8'h00) else $error("byte2 not zero");
  chk_byte1_rsvd:
    assert property (reg_rd && reg_addr == ADDR_FLAGS1 |=> (reg_rdata & ~IMPL_MASK1) == 8'h00)
      else $error("byte1 reserved bits set");
  chk_mapped_hit:
    assert property (reg_rd && mapped |=> reg_hit) else $error("mapped read missed");
  chk_unmapped_quiet:
    assert property (reg_rd && !mapped |=> !reg_hit && reg_rdata == READ_DEFAULT) else $error("unmapped read hit");
  chk_rdata_hold:
    assert property (!reg_rd |=> $stable(reg_rdata) && $stable(reg_hit)) else $error("read data moved");
  chk_reset_state:
    assert property ($rose(nrst) |-> reg_rdata == 8'h00 && !reg_hit && !event_out_line) else $error("bad reset state");
endmodule // eefm_sva
bind eefm_core eefm_sva u_sva (.clock, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_rdata, .reg_hit,
  .legacy_event_mask, .rx_bytes_waiting, .event_out_line);

// ==== tb/eefm_host.sv ====
// host model: register strobes as the serial command side issues them
`timescale 1ns/1ps
module eefm_host (
  input  wire logic       clock,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_hit,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  ////////////////////////////////////////
  // released lines show the inverse, so a stale value never reads as valid
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clock);
    d = reg_rdata;
    h = reg_hit;
  endtask
endmodule // eefm_host

// ==== tb/test_extended_exception_flags_mask.sv ====
// self-checking bench for the extended event flag and mask block
`timescale 1ns/1ps
module test_extended_exception_flags_mask;
  import eefm_pkg::*;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  legacy = 8'h00;
  logic [11:0] ev = 12'h000;
  logic        ack_req = 1'b0;
  logic        rx_wait = 1'b0;
  logic        enc = 1'b0;
  logic        plain_ok = 1'b0;
  logic [7:0]  seq = 8'h00;
  logic        reg_wr, reg_rd, reg_hit, event_out_line;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [31:0] seed = 32'h9565DF0D;
  logic [31:0] r;
  logic [7:0]  m [3];
  int          num_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  eefm_core #(.SEQ_W(8)) u_dut (.clock(clock), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .legacy_event_mask(legacy), .serial_buffer_overflow(ev[0]), .radio_buffer_overflow(ev[1]),
    .reg_write_failed(ev[2]), .ack_missing(ev[3]), .payload_crc_error(ev[4]), .header_crc_error(ev[5]),
    .ack_seq_mismatch(ev[6]), .frame_type_unsupported(ev[7]), .packet_sent(ev[8]),
    .packet_ack_requested(ack_req), .ack_received(ev[9]), .rx_bytes_waiting(rx_wait),
    .rx_packet_valid(ev[10]), .rx_packet_encrypted(enc), .rx_seq_num(seq), .accept_plaintext(plain_ok),
    .pairing_start(ev[11]), .event_out_line(event_out_line));
  eefm_host u_host (.clock(clock), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  initial forever #12.5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      close_out();
    end
  end
  ////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] gate(input logic [7:0] f, input logic [7:0] k, input logic [7:0] l);
    return {7'h00, (|(f & k)) && l == 8'h00};
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, s);
      num_errors++;
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       h;
    u_host.rd(a, d, h);
    chk($sformatf("reg %h", a), e, d);
  endtask
  task automatic ln(input logic [7:0] e);
    @(posedge clock);
    chk("line", e, {7'h00, event_out_line});
  endtask
  task automatic pulse(input logic [11:0] v);
    @(posedge clock);
    ev <= v;
    @(posedge clock);
    ev <= 12'h000;
  endtask
  task automatic rst_chk();
    logic [7:0] d;
    logic       h;
    nrst <= 1'b0;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    // the saved-copy load takes the first edge, so no access there
    repeat (2) @(posedge clock);
    for (int a = 0; a < 9; a++) rc(a < 3 ? ADDR_NVMASK2 + 8'(a) : ADDR_FLAGS2 + 8'(a - 3), 8'h00);
    u_host.rd(8'h83, d, h);
    chk("hit", 8'h00, {7'h00, h});
    $display("test reset done");
  endtask
  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    logic [7:0] sq [4] = '{8'h0A, 8'h09, 8'h0B, 8'h0C};
    logic [7:0] ex [4] = '{8'h00, 8'h08, 8'h10, 8'h00};
    rst_chk();
    for (int i = 0; i < 8; i++) begin
      u_host.wr(ADDR_MASK0, 8'h01 << i);
      pulse(12'h001 << i);
      ln(8'h01);
      rc(ADDR_FLAGS0, 8'h01 << i);
      rc(ADDR_FLAGS0, 8'h01 << i);
      u_host.wr(ADDR_FLAGS0, ~(8'h01 << i));
      ln(8'h00);
    end
    $display("test byte0 events done");
    u_host.wr(ADDR_MASK0, 8'hFF);
    repeat (24) begin
      r = xs();
      pulse({4'h0, r[7:0]});
      u_host.wr(ADDR_FLAGS0, r[15:8]);
      rc(ADDR_FLAGS0, r[7:0] & r[15:8]);
      @(posedge clock);
      legacy <= r[23:16] & {8{r[24]}};
      ln(gate(r[7:0] & r[15:8], 8'hFF, r[23:16] & {8{r[24]}}));
      u_host.wr(ADDR_FLAGS0, 8'h00);
      legacy <= 8'h00;
    end
    $display("test random clear done");
    u_host.wr(ADDR_MASK0, 8'h00);
    u_host.wr(ADDR_MASK1, IMPL_MASK1);
    pulse(12'h100);
    rc(ADDR_FLAGS1, 8'h01);
    u_host.wr(ADDR_FLAGS1, 8'h00);
    ack_req <= 1'b1;
    pulse(12'h100);
    ack_req <= 1'b0;
    rc(ADDR_FLAGS1, 8'h00);
    pulse(12'h200);
    ln(8'h01);
    rc(ADDR_FLAGS1, 8'h01);
    u_host.wr(ADDR_FLAGS1, 8'h00);
    ack_req <= 1'b1;
    pulse(12'h100);
    ack_req <= 1'b0;
    pulse(12'h008);
    pulse(12'h200);
    rc(ADDR_FLAGS1, 8'h00);
    rc(ADDR_FLAGS0, 8'h08);
    u_host.wr(ADDR_FLAGS0, 8'h00);
    rx_wait <= 1'b1;
    u_host.wr(ADDR_FLAGS1, 8'h00);
    rc(ADDR_FLAGS1, 8'h02);
    rx_wait <= 1'b0;
    rc(ADDR_FLAGS1, 8'h00);
    pulse(12'h400);
    rc(ADDR_FLAGS1, 8'h00);
    plain_ok <= 1'b1;
    pulse(12'h400);
    rc(ADDR_FLAGS1, 8'h04);
    enc <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      u_host.wr(ADDR_FLAGS1, 8'h00);
      seq <= sq[i];
      pulse(12'h400);
      rc(ADDR_FLAGS1, ex[i]);
    end
    pulse(12'h800);
    u_host.wr(ADDR_FLAGS1, 8'hFF);
    rc(ADDR_FLAGS1, 8'h20);
    $display("test byte1 events done");
    for (int a = 0; a < 3; a++) begin
      r = xs();
      m[a] = r[15:8];
      u_host.wr(ADDR_NVMASK2 + 8'(a), r[7:0]);
      rc(ADDR_NVMASK2 + 8'(a), r[7:0]);
      u_host.wr(ADDR_MASK2 + 8'(a), m[a]);
      rc(ADDR_MASK2 + 8'(a), m[a]);
    end
    ln(gate(8'h20, m[1], 8'h00));
    $display("test masks done");
    rst_chk();
    close_out();
  end
endmodule // test_extended_exception_flags_mask
